// file: hdl/rsbv_reset_ctrl.sv
// Reset entry and boot vector selection for a small controller.
// Assumes reset sources are async pins; flash answers in fixed cycles.
//
// Overview of operation
// - Any reset source halts the core
// - Registers reset; power-on-only bits keep otherwise
// - Reset clears interrupt enables, stops timers
// - Reset leaves RAM contents untouched
// - Port latches one, drivers open-drain
// - Weak pull-ups on during and after reset
// - Power-on or supply reset drives pin low
// - Exit clears program counter, internal clock
// - Exit enables dog timer; default vector zero
// - Eight reset sources each force reset
// - Signature is byte below lock byte
// - Signature 0xA5 means bootloader present
// - Any other value means no bootloader
// - Bootloader present: fetch from bootloader vector
// - No bootloader: fetch from address zero
// - Dog timer starts with longest interval
// - Dog timer reset leaves pin alone
module rsbv_reset_ctrl
   import rsbv_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic por_req_i,
   input wire logic ext_reset_pin_n_i,
   input wire logic cmp_req_i,
   input wire logic sw_req_i,
   input wire logic supply_req_i,
   input wire logic dog_req_i,
   input wire logic clkmiss_req_i,
   input wire logic flash_err_i,
   input wire logic [7:0] flash_data_i,
   output logic flash_rd_o,
   output logic [15:0] flash_addr_o,
   output logic core_halt_o,
   output logic reg_rst_o,
   output logic por_rst_o,
   output logic int_en_clr_o,
   output logic timer_stop_o,
   output logic ram_hold_o,
   output logic [7:0] port_latch_o,
   output logic port_open_drain_o,
   output logic weak_pullup_o,
   output logic ext_reset_pin_n_o,
   output logic ext_reset_pin_n_oe_n_o,
   output logic [15:0] program_counter_o,
   output logic pc_load_o,
   output logic clk_sel_o,
   output logic dog_timer_en_o,
   output logic [2:0] dog_timer_ival_o,
   output logic boot_present_o,
   output logic [RSBV_NSRC-1:0] reset_cause_o
);
   rsbv_state_t state_reg;
   rsbv_state_t state_next;
   logic [RSBV_NSRC-1:0] src_raw;
   logic [RSBV_NSRC-1:0] src_sync;
   logic any_src;
   logic rd_start;
   logic rd_done;
   logic [7:0] sig_byte;
   logic boot_reg;
   logic pin_drive_reg;
   logic [RSBV_NSRC-1:0] cause_reg;
   logic [15:0] pc_reg;
   logic pc_load_reg;
   logic halt_reg;

   // Signature decode
   function automatic logic rsbv_is_boot(input logic [7:0] b);
      return b == RSBV_BOOT_MARK;
   endfunction

   // ==========================================
   // Source gathering
   // eight reset sources
   // own pin drive not read back as request
   assign src_raw = {flash_err_i, clkmiss_req_i, dog_req_i, supply_req_i,
                     sw_req_i, cmp_req_i,
                     ~ext_reset_pin_n_i & ~pin_drive_reg, por_req_i};

   rsbv_sync u_sync (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(src_raw),
      .rst_val_i('0),
      .sync_o(src_sync)
   );

   assign any_src = |src_sync;

   // ==========================================
   // Sequencing
   // wait for release
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         RSBV_ST_HOLD: begin
            if (!any_src) begin
               state_next = RSBV_ST_READ;
            end
         end
         RSBV_ST_READ: begin
            state_next = RSBV_ST_WAIT;
         end
         RSBV_ST_WAIT: begin
            if (any_src) begin
               state_next = RSBV_ST_HOLD;
            end else if (rd_done) begin
               state_next = RSBV_ST_DECIDE;
            end
         end
         RSBV_ST_DECIDE: begin
            state_next = RSBV_ST_RUN;
         end
         RSBV_ST_RUN: begin
            if (any_src) begin
               state_next = RSBV_ST_HOLD;
            end
         end
         default: begin
            state_next = RSBV_ST_HOLD;
         end
      endcase
      if (any_src) begin
         state_next = RSBV_ST_HOLD;
      end
   end

   // State register
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= RSBV_ST_HOLD;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rd_start = (state_reg == RSBV_ST_READ);

   rsbv_flash_rd u_rd (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(rd_start),
      .flash_data_i(flash_data_i),
      .flash_rd_o(flash_rd_o),
      .flash_addr_o(flash_addr_o),
      .done_o(rd_done),
      .byte_o(sig_byte)
   );

   // ==========================================
   // Boot decision
   // marker compare
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         boot_reg <= 1'b0;
      end else if (state_reg == RSBV_ST_WAIT && rd_done && !any_src) begin
         boot_reg <= rsbv_is_boot(sig_byte);
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pc_reg <= RSBV_RESET_VEC;
         pc_load_reg <= 1'b0;
      end else if (state_reg == RSBV_ST_DECIDE && !any_src) begin
         pc_reg <= boot_reg ? RSBV_BOOT_VEC : RSBV_RESET_VEC;
         pc_load_reg <= 1'b1;
      end else if (state_reg != RSBV_ST_RUN) begin
         pc_reg <= RSBV_RESET_VEC;
         pc_load_reg <= 1'b0;
      end else begin
         pc_load_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         halt_reg <= 1'b1;
      end else begin
         halt_reg <= (state_next != RSBV_ST_RUN);
      end
   end

   // ==========================================
   // Reset pin drive
   // pin low for supply
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_drive_reg <= 1'b1;
      end else if (src_sync[RSBV_SRC_POR] || src_sync[RSBV_SRC_SUPPLY]) begin
         pin_drive_reg <= 1'b1;
      end else if (state_reg == RSBV_ST_DECIDE) begin
         pin_drive_reg <= 1'b0;
      end
   end

   // Cause record; latest reset source set
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cause_reg <= 8'h01;
      end else if (any_src) begin
         cause_reg <= src_sync;
      end
   end

   // ==========================================
   // Outputs
   assign core_halt_o = halt_reg;
   assign reg_rst_o = halt_reg;
   assign por_rst_o = halt_reg & cause_reg[RSBV_SRC_POR];
   assign int_en_clr_o = halt_reg;
   assign timer_stop_o = halt_reg;
   assign ram_hold_o = 1'b1;
   assign port_latch_o = RSBV_PORT_LATCH_RST;
   assign port_open_drain_o = halt_reg;
   assign weak_pullup_o = 1'b1;
   assign ext_reset_pin_n_o = 1'b0;
   assign ext_reset_pin_n_oe_n_o = ~pin_drive_reg;
   assign program_counter_o = pc_reg;
   assign pc_load_o = pc_load_reg;
   assign clk_sel_o = RSBV_CLK_SEL_INT;
   assign dog_timer_en_o = ~halt_reg;
   assign dog_timer_ival_o = RSBV_DOG_MAX_IVAL;
   assign boot_present_o = boot_reg;
   assign reset_cause_o = cause_reg;

   // ==========================================
   // Checks
   sequence s_release;
      state_reg == RSBV_ST_DECIDE && !any_src;
   endsequence

   property p_halt;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      any_src |=> core_halt_o;
   endproperty
   a_halt: assert property (p_halt) else $error("core ran in reset");

   property p_boot_vec;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      s_release and boot_reg |=> program_counter_o == RSBV_BOOT_VEC;
   endproperty
   a_boot_vec: assert property (p_boot_vec) else $error("bad boot vec");

   property p_zero_vec;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      s_release and !boot_reg |=> program_counter_o == RSBV_RESET_VEC;
   endproperty
   a_zero_vec: assert property (p_zero_vec) else $error("bad zero vec");

   property p_mark;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      state_reg == RSBV_ST_WAIT && rd_done && !any_src
         |=> boot_reg == (($past(sig_byte)) == 8'ha5);
   endproperty
   a_mark: assert property (p_mark) else $error("marker wrong");

   property p_pin_por;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      src_sync[RSBV_SRC_POR] |=> !ext_reset_pin_n_oe_n_o;
   endproperty
   a_pin_por: assert property (p_pin_por) else $error("pin not low");

   property p_pin_rel;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      s_release |=> ext_reset_pin_n_oe_n_o;
   endproperty
   a_pin_rel: assert property (p_pin_rel) else $error("pin kept low");

   sequence s_read_done;
      flash_rd_o && flash_addr_o == RSBV_SIG_ADDR ##1 flash_rd_o ##1 rd_done;
   endsequence

   property p_read;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      rd_start |=> s_read_done;
   endproperty
   a_read: assert property (p_read) else $error("signature read late");

   property p_pin_dog;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      src_sync == 8'h20 && ext_reset_pin_n_oe_n_o
         |=> ext_reset_pin_n_oe_n_o;
   endproperty
   a_pin_dog: assert property (p_pin_dog) else $error("dog drove pin");

   property p_hold;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      any_src |=> state_reg == RSBV_ST_HOLD;
   endproperty
   a_hold: assert property (p_hold) else $error("left hold early");

   property p_dog;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      pc_load_o |-> dog_timer_en_o && dog_timer_ival_o == 3'h7;
   endproperty
   a_dog: assert property (p_dog) else $error("dog timer off");
endmodule : rsbv_reset_ctrl

// file: common/rsbv_pkg.sv
// Constants shared by the reset entry and boot vector block.
// Assumes a single 50 MHz system clock and an active-high async reset.
package rsbv_pkg;
   // ==========================================
   // Reset source indices
   localparam int RSBV_NSRC = 8;
   localparam int RSBV_SRC_POR = 0;
   localparam int RSBV_SRC_PIN = 1;
   localparam int RSBV_SRC_CMP = 2;
   localparam int RSBV_SRC_SW = 3;
   localparam int RSBV_SRC_SUPPLY = 4;
   localparam int RSBV_SRC_DOG = 5;
   localparam int RSBV_SRC_CLKMISS = 6;
   localparam int RSBV_SRC_FLASH = 7;
   // ==========================================
   // Boot selection values
   localparam logic [7:0] RSBV_BOOT_MARK = 8'ha5;
   localparam logic [15:0] RSBV_RESET_VEC = 16'h0000;
   localparam logic [15:0] RSBV_LOCK_ADDR = 16'h1fff;
   localparam logic [15:0] RSBV_SIG_ADDR = 16'h1ffe;
   localparam logic [15:0] RSBV_BOOT_VEC = 16'h1e00;
   // ==========================================
   // Reset values of outputs; flash read latency
   localparam logic [7:0] RSBV_PORT_LATCH_RST = 8'hff;
   localparam logic [2:0] RSBV_DOG_MAX_IVAL = 3'h7;
   localparam logic RSBV_CLK_SEL_INT = 1'h0;
   localparam logic [1:0] RSBV_FLASH_LAT = 2'h2;
   // ==========================================
   // Machine states
   typedef enum logic [2:0] {
      RSBV_ST_HOLD,
      RSBV_ST_READ,
      RSBV_ST_WAIT,
      RSBV_ST_DECIDE,
      RSBV_ST_RUN
   } rsbv_state_t;
endpackage : rsbv_pkg

// file: hdl/rsbv_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs come from outside the ref_clk_i domain.
module rsbv_sync
   import rsbv_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic [RSBV_NSRC-1:0] async_i,
   input wire logic [RSBV_NSRC-1:0] rst_val_i,
   output logic [RSBV_NSRC-1:0] sync_o
);
   logic [RSBV_NSRC-1:0] s1_reg;
   logic [RSBV_NSRC-1:0] s2_reg;
   logic [RSBV_NSRC-1:0] s3_reg;
   logic [RSBV_NSRC-1:0] out_reg;

   // ==========================================
   // Stage chain; first stage feeds only the second
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= async_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Update once stages two and three agree
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         out_reg <= '0;
      end else begin
         out_reg <= (s2_reg & s3_reg) | (out_reg & (s2_reg | s3_reg));
      end
   end

   // Caller may force bits on
   assign sync_o = out_reg | rst_val_i;
endmodule : rsbv_sync

// file: hdl/rsbv_flash_rd.sv
// Single-byte flash reader for the boot signature.
// Assumes a flash port with fixed latency and no wait signal.
module rsbv_flash_rd
   import rsbv_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic start_i,
   input wire logic [7:0] flash_data_i,
   output logic flash_rd_o,
   output logic [15:0] flash_addr_o,
   output logic done_o,
   output logic [7:0] byte_o
);
   logic [1:0] cnt_reg;
   logic busy_reg;
   logic [7:0] byte_reg;
   logic done_reg;

   // ==========================================
   // Latency counter
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         busy_reg <= 1'b0;
         cnt_reg <= 2'h0;
      end else if (start_i && !busy_reg) begin
         busy_reg <= 1'b1;
         cnt_reg <= RSBV_FLASH_LAT;
      end else if (busy_reg) begin
         cnt_reg <= cnt_reg - 2'h1;
         if (cnt_reg == 2'h1) begin
            busy_reg <= 1'b0;
         end
      end
   end

   // Capture returned byte on the last cycle; done rises on the same edge as the capture
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         byte_reg <= 8'h00;
         done_reg <= 1'b0;
      end else begin
         done_reg <= busy_reg && (cnt_reg == 2'h1);
         if (busy_reg && cnt_reg == 2'h1) begin
            byte_reg <= flash_data_i;
         end
      end
   end

   assign flash_rd_o = busy_reg;
   // Byte just below the lock byte
   assign flash_addr_o = RSBV_SIG_ADDR;
   // Byte is held in a flop, valid while done is high
   assign done_o = done_reg;
   assign byte_o = byte_reg;
endmodule : rsbv_flash_rd

// file: verification/rsbv_flash_model.sv
// Flash model answering the boot signature read.
// Assumes reads are level requests with data valid during them.
module rsbv_flash_model
   import rsbv_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic flash_rd_i,
   input wire logic [15:0] flash_addr_i,
   input wire logic [7:0] sig_i,
   output logic [7:0] flash_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] junk_reg = 8'h3c;
   // ==========================================
   // Data pattern that changes every cycle
   always_ff @(posedge ref_clk_i) begin
      junk_reg <= ~junk_reg + 8'h01;
   end
   // Signature byte below the lock byte, junk elsewhere
   always_comb begin
      if (flash_rd_i && flash_addr_i == RSBV_SIG_ADDR) begin
         flash_data_o = sig_i;
      end else begin
         flash_data_o = junk_reg;
      end
   end
endmodule // rsbv_flash_model

// file: verification/rsbv_reset_ctrl_tb_top.sv
// Testbench for the reset entry and boot vector block.
// Assumes the flash model file and pull-up on the reset pin.
`define CHK(n, e, g) chk(n, 16'(e), 16'(g))
module rsbv_reset_ctrl_tb_top
   import rsbv_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, sys_rst = 1'b1;
   logic [7:0] src = 8'h00, sig = 8'ha5, fdata, port_latch, cause;
   logic rd, halt, reg_rst, por_rst, ie_clr, tstop, ram_hold, od, pull;
   logic pin_o, oe_n, pc_load, clk_sel, dog_en, boot;
   logic [15:0] faddr, pc;
   logic [2:0] ival;
   wire pin_n = (oe_n ? 1'b1 : pin_o) & ~src[RSBV_SRC_PIN];
   int n_mismatch = 0, n_checks = 0, n_cyc = 0, n_load = 0, n_rd = 0;
   // ==========================================
   // Clock, timeout and load counter
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      n_cyc++;
      if (pc_load === 1'b1) n_load++;
      if (rd === 1'b1) n_rd++;
      if (n_cyc == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   rsbv_reset_ctrl i_rsbv_reset_ctrl (.ref_clk_i(ref_clk),
      .sys_rst_i(sys_rst), .por_req_i(src[RSBV_SRC_POR]),
      .ext_reset_pin_n_i(pin_n), .cmp_req_i(src[RSBV_SRC_CMP]),
      .sw_req_i(src[RSBV_SRC_SW]), .supply_req_i(src[RSBV_SRC_SUPPLY]),
      .dog_req_i(src[RSBV_SRC_DOG]), .clkmiss_req_i(src[RSBV_SRC_CLKMISS]),
      .flash_err_i(src[RSBV_SRC_FLASH]), .flash_data_i(fdata),
      .flash_rd_o(rd), .flash_addr_o(faddr), .core_halt_o(halt),
      .reg_rst_o(reg_rst), .por_rst_o(por_rst), .int_en_clr_o(ie_clr),
      .timer_stop_o(tstop), .ram_hold_o(ram_hold),
      .port_latch_o(port_latch), .port_open_drain_o(od),
      .weak_pullup_o(pull), .ext_reset_pin_n_o(pin_o),
      .ext_reset_pin_n_oe_n_o(oe_n), .program_counter_o(pc),
      .pc_load_o(pc_load), .clk_sel_o(clk_sel), .dog_timer_en_o(dog_en),
      .dog_timer_ival_o(ival), .boot_present_o(boot),
      .reset_cause_o(cause));
   rsbv_flash_model i_rsbv_flash_model (.ref_clk_i(ref_clk),
      .flash_rd_i(rd), .flash_addr_i(faddr), .sig_i(sig),
      .flash_data_o(fdata));
   // ==========================================
   // Comparison and closing
   task automatic chk(input string nm, input logic [15:0] e,
         input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Outputs that hold in and out of reset
   task automatic chk_static();
      `CHK("latch", RSBV_PORT_LATCH_RST, port_latch);
      `CHK("pullup", 1'b1, pull);
      `CHK("ram_hold", 1'b1, ram_hold);
      `CHK("pin_level", 1'b0, pin_o);
   endtask
   // Wait for the first fetch and judge the exit state
   task automatic wait_boot();
      logic [15:0] exp_pc;
      int n_rd0;
      exp_pc = (sig == RSBV_BOOT_MARK) ? RSBV_BOOT_VEC : RSBV_RESET_VEC;
      n_rd0 = n_rd;
      for (int i = 0; i < 60 && pc_load !== 1'b1; i++) @(negedge ref_clk);
      `CHK("pc_load", 1'b1, pc_load);
      `CHK("rd_cycles", RSBV_FLASH_LAT, n_rd - n_rd0);
      `CHK("pc", exp_pc, pc);
      `CHK("boot", sig == RSBV_BOOT_MARK, boot);
      @(negedge ref_clk);
      `CHK("halt", 1'b0, halt);
      `CHK("clk_sel", RSBV_CLK_SEL_INT, clk_sel);
      `CHK("dog_en", 1'b1, dog_en);
      `CHK("ival", RSBV_DOG_MAX_IVAL, ival);
      chk_static();
   endtask
   // One source: entry state, pin drive, cause and boot
   task automatic t_source(input int idx);
      logic exp_oe;
      exp_oe = !(idx == RSBV_SRC_POR || idx == RSBV_SRC_SUPPLY);
      src[idx] = 1'b1;
      for (int i = 0; i < 10 && halt !== 1'b1; i++) @(negedge ref_clk);
      repeat (3) @(negedge ref_clk);
      `CHK("halt", 1'b1, halt);
      `CHK("reg_rst", 1'b1, reg_rst);
      `CHK("por_rst", idx == RSBV_SRC_POR, por_rst);
      `CHK("int_en_clr", 1'b1, ie_clr);
      `CHK("timer_stop", 1'b1, tstop);
      `CHK("open_drain", 1'b1, od);
      chk_static();
      if (idx != RSBV_SRC_PIN) begin
         `CHK("pin_oe_n", exp_oe, oe_n);
      end
      src[idx] = 1'b0;
      wait_boot();
      `CHK("cause", 1'b1, cause[idx]);
   endtask
   // Signature values: marker and near misses
   task automatic t_sig();
      logic [7:0] tab [5] = '{8'ha5, 8'ha4, 8'h25, 8'hff, 8'h00};
      foreach (tab[k]) begin
         sig = tab[k];
         src[RSBV_SRC_SW] = 1'b1;
         repeat (6) @(negedge ref_clk);
         src[RSBV_SRC_SW] = 1'b0;
         wait_boot();
         `CHK("sig_addr", RSBV_SIG_ADDR, faddr);
      end
   endtask
   // Two sources overlap, then a restart in mid-sequence
   task automatic t_overlap();
      int n0;
      src[RSBV_SRC_CMP] = 1'b1;
      src[RSBV_SRC_FLASH] = 1'b1;
      repeat (8) @(negedge ref_clk);
      n0 = n_load;
      src[RSBV_SRC_CMP] = 1'b0;
      repeat (20) @(negedge ref_clk);
      `CHK("held_loads", n0, n_load);
      src[RSBV_SRC_FLASH] = 1'b0;
      repeat (3) @(negedge ref_clk);
      src[RSBV_SRC_CLKMISS] = 1'b1;
      repeat (20) @(negedge ref_clk);
      `CHK("restart_halt", 1'b1, halt);
      `CHK("restart_loads", n0, n_load);
      src[RSBV_SRC_CLKMISS] = 1'b0;
      wait_boot();
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (12) @(negedge ref_clk);
      sys_rst = 1'b0;
      wait_boot();
      for (int s = 0; s < RSBV_NSRC; s++) t_source(s);
      sig = 8'h00;
      t_source(RSBV_SRC_DOG);
      t_sig();
      t_overlap();
      end_sim();
   end
endmodule // rsbv_reset_ctrl_tb_top
